// File: drec_pkg.sv
// Purpose: Shared constants for the dual rotary knob counter.
// Assumes: 40 MHz mclk, 32-bit register port with byte addresses.
// Notes:   Summary of operation below.
// Summary of operation
// - Enable selects none, knob one, knob two, or both knobs.
// - Each knob's A and B channel is picked from any input port pin.
// - Each knob has its own debounce time, 1 to 100 ms.
// - Each knob has its own quiet time, 1 to 1000 ms.
// - Each knob has a type setting, 1 or 2.
// - Each knob keeps a signed 32-bit position count readable by software.
// - Software may preset a count; counting continues from the preset.
// - Left click decrements the count, right click increments it.
// - Event fires once quiet time passes after last rotation; rotation restarts.
// - Each knob has its own event source.
package drec_pkg;
   localparam int unsigned DREC_CLK_HZ   = 40_000_000;
   localparam int unsigned DREC_CLK_NS   = 25;
   localparam int unsigned DREC_MS_NS    = 1_000_000;
   // Cycles per millisecond tick
   localparam int unsigned DREC_TICK_CYC = DREC_MS_NS / DREC_CLK_NS;

   localparam logic [7:0]  DREC_OFF_ENABLE = 8'h00;
   localparam logic [7:0]  DREC_OFF_ROUTE  = 8'h04;
   localparam logic [7:0]  DREC_OFF_SETTLE = 8'h08;
   localparam logic [7:0]  DREC_OFF_QUIET1 = 8'h0C;
   localparam logic [7:0]  DREC_OFF_QUIET2 = 8'h10;
   localparam logic [7:0]  DREC_OFF_TYPE   = 8'h14;
   localparam logic [7:0]  DREC_OFF_COUNT1 = 8'h18;
   localparam logic [7:0]  DREC_OFF_COUNT2 = 8'h1C;
   localparam logic [7:0]  DREC_OFF_STATUS = 8'h20;
   localparam logic [7:0]  DREC_OFF_MASK   = 8'h24;

   // Route: channel c uses bits [c*8 +: 5], order A1,B1,A2,B2
   localparam int unsigned DREC_ROUTE_STRIDE = 8;
   localparam int unsigned DREC_PIN_W        = 5;
   // Settle: knob k uses bits [k*16 +: 7]
   localparam int unsigned DREC_SETTLE_STRIDE = 16;
   localparam int unsigned DREC_SETTLE_W      = 7;
   localparam int unsigned DREC_QUIET_W       = 10;
   // Type: knob k uses bits [k*8 +: 2]
   localparam int unsigned DREC_TYPE_STRIDE   = 8;

   localparam logic [6:0]  DREC_SETTLE_MIN = 7'h01;
   localparam logic [6:0]  DREC_SETTLE_MAX = 7'h64;
   localparam logic [9:0]  DREC_QUIET_MIN  = 10'h001;
   localparam logic [9:0]  DREC_QUIET_MAX  = 10'h3E8;
   localparam logic [1:0]  DREC_TYPE_HALF  = 2'h2;

   localparam logic [1:0]  DREC_ENABLE_RST = 2'h0;
   localparam logic [31:0] DREC_ROUTE_RST  = 32'h0302_0100;
   localparam logic [31:0] DREC_SETTLE_RST = 32'h0005_0005;
   localparam logic [9:0]  DREC_QUIET_RST  = 10'h064;
   localparam logic [1:0]  DREC_TYPE_RST   = 2'h1;
endpackage : drec_pkg

// File: drec_settle.sv
// Purpose: Millisecond debounce of one already synchronised channel.
// Assumes: din is synchronous to mclk; tick pulses once per ms.
// Notes:   A change is taken on the limit-th tick seen while the new level holds steady.
module drec_settle
   import drec_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic       tick,
   input  wire logic [6:0] limit,
   input  wire logic       din,
   output logic            dout
);
   logic       stable_ff;
   logic [6:0] cnt_ff;
   logic       nxt_stable;
   logic [6:0] nxt_cnt;

   // Any bounce back to the held level restarts the wait
   always_comb
   begin
      nxt_stable = stable_ff;
      nxt_cnt    = cnt_ff;
      if (din == stable_ff)
      begin
         nxt_cnt = 7'h00;
      end
      else if (tick)
      begin
         if (cnt_ff + 7'h01 >= limit)
         begin
            nxt_stable = din;
            nxt_cnt    = 7'h00;
         end
         else
         begin
            nxt_cnt = cnt_ff + 7'h01;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stable_ff <= 1'b0;
         cnt_ff    <= 7'h00;
      end
      else
      begin
         stable_ff <= nxt_stable;
         cnt_ff    <= nxt_cnt;
      end
   end

   assign dout = stable_ff;
endmodule : drec_settle

// File: drec_top.sv
// Purpose: Dual quadrature knob counter with debounce and quiet events.
// Assumes: Knob pins arrive on io_pins asynchronously to mclk.
// Notes:   Registers on a plain strobe port, read data one cycle later.
module drec_top
   import drec_pkg::*;
#(
   parameter int unsigned TICK_CYC = DREC_TICK_CYC
)
(
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic [31:0] io_pins,
   input  wire logic [7:0]  bus_addr,
   input  wire logic [31:0] bus_wdata,
   input  wire logic        bus_wr,
   input  wire logic        bus_rd,
   output logic      [31:0] bus_rdata,
   output logic             first_knob_event,
   output logic             second_knob_event,
   output logic             irq
);
   // Millisecond time base
   logic [15:0] tick_cnt_ff;
   logic        tick_ff;
   logic [15:0] nxt_tick_cnt;
   logic        nxt_tick;

   always_comb
   begin
      nxt_tick     = 1'b0;
      nxt_tick_cnt = tick_cnt_ff + 16'h0001;
      if (tick_cnt_ff >= 16'(TICK_CYC - 1))
      begin
         nxt_tick_cnt = 16'h0000;
         nxt_tick     = 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tick_cnt_ff <= 16'h0000;
         tick_ff     <= 1'b0;
      end
      else
      begin
         tick_cnt_ff <= nxt_tick_cnt;
         tick_ff     <= nxt_tick;
      end
   end

   // Two-stage synchroniser on every pin before routing
   logic [31:0] sync1_ff;
   logic [31:0] sync2_ff;

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync1_ff <= 32'h0000_0000;
         sync2_ff <= 32'h0000_0000;
      end
      else
      begin
         sync1_ff <= io_pins;
         sync2_ff <= sync1_ff;
      end
   end

   // Configuration registers
   logic [1:0]       enable_ff;
   logic [31:0]      route_ff;
   logic [31:0]      settle_ff;
   logic [1:0][9:0]  quiet_ff;
   logic [1:0][1:0]  type_ff;
   logic [1:0]       mask_ff;
   logic [1:0]       nxt_enable;
   logic [31:0]      nxt_route;
   logic [31:0]      nxt_settle;
   logic [1:0][9:0]  nxt_quiet;
   logic [1:0][1:0]  nxt_type;
   logic [1:0]       nxt_mask;

   always_comb
   begin
      nxt_enable = enable_ff;
      nxt_route  = route_ff;
      nxt_settle = settle_ff;
      nxt_quiet  = quiet_ff;
      nxt_type   = type_ff;
      nxt_mask   = mask_ff;
      if (bus_wr)
      begin
         case (bus_addr)
            DREC_OFF_ENABLE: nxt_enable = bus_wdata[1:0];
            DREC_OFF_ROUTE:  nxt_route  = bus_wdata;
            DREC_OFF_SETTLE: nxt_settle = bus_wdata;
            DREC_OFF_QUIET1: nxt_quiet[0] = bus_wdata[9:0];
            DREC_OFF_QUIET2: nxt_quiet[1] = bus_wdata[9:0];
            DREC_OFF_TYPE:
            begin
               nxt_type[0] = bus_wdata[1:0];
               nxt_type[1] = bus_wdata[9:8];
            end
            DREC_OFF_MASK:   nxt_mask   = bus_wdata[1:0];
            default:         nxt_mask   = mask_ff;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         enable_ff <= DREC_ENABLE_RST;
         route_ff  <= DREC_ROUTE_RST;
         settle_ff <= DREC_SETTLE_RST;
         quiet_ff  <= {DREC_QUIET_RST, DREC_QUIET_RST};
         type_ff   <= {DREC_TYPE_RST, DREC_TYPE_RST};
         mask_ff   <= 2'h0;
      end
      else
      begin
         enable_ff <= nxt_enable;
         route_ff  <= nxt_route;
         settle_ff <= nxt_settle;
         quiet_ff  <= nxt_quiet;
         type_ff   <= nxt_type;
         mask_ff   <= nxt_mask;
      end
   end

   // Channel routing and debounce, order A1, B1, A2, B2
   logic [3:0] clean;

   genvar c;
   generate
      for (c = 0; c < 4; c++)
      begin : g_chan
         logic [4:0] pin;
         logic [6:0] raw_lim;
         logic [6:0] lim;
         assign pin = route_ff[c*DREC_ROUTE_STRIDE +: DREC_PIN_W];
         assign raw_lim =
            settle_ff[(c/2)*DREC_SETTLE_STRIDE +: DREC_SETTLE_W];
         // Out-of-range settings are clamped to the legal span
         assign lim = (raw_lim < DREC_SETTLE_MIN) ? DREC_SETTLE_MIN :
                      (raw_lim > DREC_SETTLE_MAX) ? DREC_SETTLE_MAX :
                      raw_lim;
         drec_settle u_settle
         (
            .mclk  (mclk),
            .rst_n (rst_n),
            .tick  (tick_ff),
            .limit (lim),
            .din   (sync2_ff[pin]),
            .dout  (clean[c])
         );
      end
   endgenerate

   // Per-knob decode, count and quiet timer
   logic [1:0][31:0] count_ff;
   logic [1:0]       prev_a_ff;
   logic [1:0]       armed_ff;
   logic [1:0][9:0]  qcnt_ff;
   logic [1:0]       ev_ff;
   logic [1:0][31:0] nxt_count;
   logic [1:0]       nxt_prev_a;
   logic [1:0]       nxt_armed;
   logic [1:0][9:0]  nxt_qcnt;
   logic [1:0]       nxt_ev;

   genvar k;
   generate
      for (k = 0; k < 2; k++)
      begin : g_knob
         logic       a;
         logic       b;
         logic       step;
         logic [9:0] qlim;
         logic [7:0] cnt_off;
         assign a = clean[2*k];
         assign b = clean[2*k+1];
         assign cnt_off = (k == 0) ? DREC_OFF_COUNT1 : DREC_OFF_COUNT2;
         assign qlim = (quiet_ff[k] < DREC_QUIET_MIN) ? DREC_QUIET_MIN :
                       (quiet_ff[k] > DREC_QUIET_MAX) ? DREC_QUIET_MAX :
                       quiet_ff[k];
         // Type 2 counts every A edge, type 1 only A rising
         assign step = enable_ff[k] && (a != prev_a_ff[k]) &&
                       (a || (type_ff[k] == DREC_TYPE_HALF));

         always_comb
         begin
            nxt_prev_a[k] = a;
            nxt_count[k]  = count_ff[k];
            nxt_armed[k]  = armed_ff[k];
            nxt_qcnt[k]   = qcnt_ff[k];
            nxt_ev[k]     = 1'b0;
            if (step)
            begin
               // A leading B means right turn
               if (a ^ b)
                  nxt_count[k] = count_ff[k] + 32'h0000_0001;
               else
                  nxt_count[k] = count_ff[k] - 32'h0000_0001;
               nxt_armed[k] = 1'b1;
               nxt_qcnt[k]  = 10'h000;
            end
            else if (!enable_ff[k])
            begin
               nxt_armed[k] = 1'b0;
            end
            else if (armed_ff[k] && tick_ff)
            begin
               if (qcnt_ff[k] + 10'h001 >= qlim)
               begin
                  nxt_armed[k] = 1'b0;
                  nxt_ev[k]    = 1'b1;
               end
               else
               begin
                  nxt_qcnt[k] = qcnt_ff[k] + 10'h001;
               end
            end
            // Preset takes priority over a step in the same cycle
            if (bus_wr && bus_addr == cnt_off)
               nxt_count[k] = bus_wdata;
         end

         always_ff @(posedge mclk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               count_ff[k]  <= 32'h0000_0000;
               prev_a_ff[k] <= 1'b0;
               armed_ff[k]  <= 1'b0;
               qcnt_ff[k]   <= 10'h000;
               ev_ff[k]     <= 1'b0;
            end
            else
            begin
               count_ff[k]  <= nxt_count[k];
               prev_a_ff[k] <= nxt_prev_a[k];
               armed_ff[k]  <= nxt_armed[k];
               qcnt_ff[k]   <= nxt_qcnt[k];
               ev_ff[k]     <= nxt_ev[k];
            end
         end
      end
   endgenerate

   // Status, interrupt and read port
   logic [1:0]  status_ff;
   logic        irq_ff;
   logic [31:0] rdata_ff;
   logic [1:0]  nxt_status;
   logic        nxt_irq;
   logic [31:0] nxt_rdata;

   always_comb
   begin
      nxt_status = status_ff;
      nxt_rdata  = 32'h0000_0000;
      if (bus_rd)
      begin
         case (bus_addr)
            DREC_OFF_ENABLE: nxt_rdata = {30'h0, enable_ff};
            DREC_OFF_ROUTE:  nxt_rdata = route_ff;
            DREC_OFF_SETTLE: nxt_rdata = settle_ff;
            DREC_OFF_QUIET1: nxt_rdata = {22'h0, quiet_ff[0]};
            DREC_OFF_QUIET2: nxt_rdata = {22'h0, quiet_ff[1]};
            DREC_OFF_TYPE:
               nxt_rdata = {22'h0, type_ff[1], 6'h00, type_ff[0]};
            DREC_OFF_COUNT1: nxt_rdata = count_ff[0];
            DREC_OFF_COUNT2: nxt_rdata = count_ff[1];
            DREC_OFF_STATUS:
            begin
               nxt_rdata  = {30'h0, status_ff};
               nxt_status = 2'h0;
            end
            DREC_OFF_MASK:   nxt_rdata = {30'h0, mask_ff};
            default:         nxt_rdata = 32'h0000_0000;
         endcase
      end
      // New events win over a clearing read in the same cycle
      nxt_status = nxt_status | ev_ff;
      nxt_irq    = |(nxt_status & mask_ff);
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         status_ff <= 2'h0;
         irq_ff    <= 1'b0;
         rdata_ff  <= 32'h0000_0000;
      end
      else
      begin
         status_ff <= nxt_status;
         irq_ff    <= nxt_irq;
         rdata_ff  <= nxt_rdata;
      end
   end

   assign bus_rdata         = rdata_ff;
   assign irq               = irq_ff;
   assign first_knob_event  = ev_ff[0];
   assign second_knob_event = ev_ff[1];
endmodule : drec_top

// File: drec_top_chk.sv
// Purpose: Port-level checks for drec_top.
// Assumes: Mask, enable and status are shadowed from bus traffic.
// Notes:   Shadows only hold if nobody else writes the registers.
module drec_chk
   import drec_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic [31:0] io_pins,
   input  wire logic [7:0]  bus_addr,
   input  wire logic [31:0] bus_wdata,
   input  wire logic        bus_wr,
   input  wire logic        bus_rd,
   input  wire logic [31:0] bus_rdata,
   input  wire logic        first_knob_event,
   input  wire logic        second_knob_event,
   input  wire logic        irq
);
   logic [1:0] st_ff;
   logic [1:0] mk_ff;
   logic [1:0] en_ff;
   logic [1:0] ev;
   assign ev = {second_knob_event, first_knob_event};
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_ff <= 2'h0;
         mk_ff <= 2'h0;
         en_ff <= 2'h0;
      end
      else
      begin
         // An event in the read cycle must survive the clear
         if (bus_rd && bus_addr == DREC_OFF_STATUS)
            st_ff <= ev;
         else
            st_ff <= st_ff | ev;
         if (bus_wr && bus_addr == DREC_OFF_MASK)
            mk_ff <= bus_wdata[1:0];
         if (bus_wr && bus_addr == DREC_OFF_ENABLE)
            en_ff <= bus_wdata[1:0];
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence s_stat_rd;
      bus_rd && bus_addr == DREC_OFF_STATUS;
   endsequence
   property p_rd_idle;
      !$past(bus_rd) |-> bus_rdata == 32'h0;
   endproperty
   property p_unmapped;
      bus_rd && bus_addr > DREC_OFF_MASK |=> bus_rdata == 32'h0;
   endproperty
   property p_stat_rd;
      s_stat_rd ##0 ev == 2'h0 |=> bus_rdata == {30'h0, $past(st_ff)};
   endproperty
   property p_mask_rd;
      bus_rd && bus_addr == DREC_OFF_MASK |=>
         bus_rdata == {30'h0, $past(mk_ff)};
   endproperty
   property p_irq;
      // Interrupt rises with the status bit, using last cycle's mask
      irq == |(st_ff & $past(mk_ff));
   endproperty
   property p_ev1_pulse;
      first_knob_event |=> !first_knob_event [*2];
   endproperty
   property p_ev2_pulse;
      $rose(second_knob_event) |=> $fell(second_knob_event);
   endproperty
   property p_ev_en;
      first_knob_event |-> en_ff[0] || $past(en_ff[0]);
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data not zero outside a read answer");
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read returned data");
   a_stat_rd: assert property (p_stat_rd)
      else $error("status read mismatch");
   a_mask_rd: assert property (p_mask_rd)
      else $error("mask read mismatch");
   a_irq: assert property (p_irq)
      else $error("irq does not follow status and mask");
   a_ev1_pulse: assert property (p_ev1_pulse)
      else $error("first event pulse too long or repeated");
   a_ev2_pulse: assert property (p_ev2_pulse)
      else $error("second event not a single pulse");
   a_ev_en: assert property (p_ev_en)
      else $error("event from a disabled knob");
endmodule : drec_chk

bind drec_top drec_chk u_chk (.mclk(mclk), .rst_n(rst_n), .io_pins(io_pins),
   .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
   .bus_rd(bus_rd), .bus_rdata(bus_rdata), .irq(irq),
   .first_knob_event(first_knob_event), .second_knob_event(second_knob_event));

// File: drec_knob_model.sv
// Purpose: Two mechanical quadrature knobs on the pin bus.
// Assumes: Each contact chatters three times before it settles.
// Notes:   Any pin may carry any channel, so routing can be exercised.
module drec_knob_model
(
   input  wire logic        mclk,
   output logic      [31:0] io_pins
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam int HOLD = 60;
   initial io_pins = 32'h0;
   // Odd chatter count leaves the contact at its new level
   task automatic move(input int p, input int hold);
      repeat (3)
      begin
         @(posedge mclk) io_pins[p] <= !io_pins[p];
      end
      repeat (hold) @(posedge mclk);
   endtask : move
   // Right: A leads B; left: B leads A
   task automatic click(input int pa, input int pb, input bit right);
      for (int i = 0; i < 4; i++)
         move((((i % 2) == 0) == right) ? pa : pb, HOLD);
   endtask : click
endmodule : drec_knob_model

// File: testbench.sv
// Purpose: Self-checking bench for drec_top.
// Assumes: TICK_CYC of 20, so one ms is 20 cycles.
// Notes:   Quiet of 20 ms outlasts the gap between clicks.
module testbench
   import drec_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic        mclk;
   logic        rst_n;
   logic        bus_wr;
   logic        bus_rd;
   logic [7:0]  bus_addr;
   logic [31:0] bus_wdata;
   logic [31:0] bus_rdata;
   logic [31:0] io_pins;
   logic        first_knob_event;
   logic        second_knob_event;
   logic        irq;
   int          fail_count = 0;
   int          checks_done = 0;
   int          ev1_n = 0;
   int          ev2_n = 0;
   drec_knob_model km (.mclk(mclk), .io_pins(io_pins));
   drec_top #(.TICK_CYC(20)) DUT (.mclk(mclk), .rst_n(rst_n),
      .io_pins(io_pins), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .irq(irq),
      .first_knob_event(first_knob_event),
      .second_knob_event(second_knob_event));
   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   always @(posedge mclk)
   begin
      if (first_knob_event === 1'b1)
         ev1_n++;
      if (second_knob_event === 1'b1)
         ev2_n++;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      bus_wr <= 1'b1;
      bus_addr <= a;
      bus_wdata <= d;
      @(posedge mclk);
      bus_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge mclk);
      bus_rd <= 1'b1;
      bus_addr <= a;
      @(posedge mclk);
      bus_rd <= 1'b0;
      @(negedge mclk);
      chk(bus_rdata, exp);
   endtask : rd
   task automatic t_reset();
      logic [7:0]  ad [11] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14,
                               8'h18, 8'h1C, 8'h20, 8'h24, 8'h28};
      logic [31:0] ex [11] = '{32'h0, 32'h03020100, 32'h00050005, 32'h64,
                               32'h64, 32'h101, 32'h0, 32'h0, 32'h0, 32'h0,
                               32'h0};
      for (int i = 0; i < 11; i++)
         rd(ad[i], ex[i]);
   endtask : t_reset
   task automatic t_config();
      // Settings read back as written; limits apply only where used
      wr(DREC_OFF_SETTLE, 32'h00FF0000);
      rd(DREC_OFF_SETTLE, 32'h00FF0000);
      wr(DREC_OFF_QUIET1, 32'h000003FF);
      rd(DREC_OFF_QUIET1, 32'h000003FF);
      wr(DREC_OFF_SETTLE, 32'h00020002);
      wr(DREC_OFF_QUIET1, 32'h14);
      wr(DREC_OFF_QUIET2, 32'h14);
      wr(DREC_OFF_MASK, 32'h3);
      wr(DREC_OFF_ENABLE, 32'h3);
      rd(DREC_OFF_ENABLE, 32'h3);
   endtask : t_config
   task automatic t_turn();
      ev1_n = 0;
      km.click(0, 1, 1'b1);
      km.click(0, 1, 1'b1);
      repeat (300) @(posedge mclk);
      rd(DREC_OFF_COUNT1, 32'h2);
      chk(ev1_n, 1);
      chk({31'h0, irq}, 32'h1);
      rd(DREC_OFF_STATUS, 32'h1);
      repeat (2) @(posedge mclk);
      chk({31'h0, irq}, 32'h0);
      for (int i = 0; i < 3; i++)
         km.click(0, 1, 1'b0);
      repeat (300) @(posedge mclk);
      rd(DREC_OFF_COUNT1, 32'hFFFFFFFF);
   endtask : t_turn
   task automatic t_preset();
      wr(DREC_OFF_COUNT1, 32'h7FFFFFFF);
      km.click(0, 1, 1'b1);
      repeat (300) @(posedge mclk);
      rd(DREC_OFF_COUNT1, 32'h80000000);
      rd(DREC_OFF_STATUS, 32'h1);
   endtask : t_preset
   task automatic t_type2();
      // Half type steps on both A edges; the A fall is late in the click
      wr(DREC_OFF_TYPE, 32'h201);
      ev1_n = 0;
      ev2_n = 0;
      km.click(2, 3, 1'b1);
      repeat (400) @(posedge mclk);
      rd(DREC_OFF_COUNT2, 32'h2);
      rd(DREC_OFF_STATUS, 32'h2);
      chk(ev1_n, 0);
      chk(ev2_n, 1);
   endtask : t_type2
   task automatic t_route();
      wr(DREC_OFF_ROUTE, 32'h03021E09);
      wr(DREC_OFF_COUNT1, 32'h0);
      km.click(9, 30, 1'b1);
      km.click(0, 1, 1'b1);
      repeat (300) @(posedge mclk);
      rd(DREC_OFF_COUNT1, 32'h1);
      rd(DREC_OFF_STATUS, 32'h1);
   endtask : t_route
   task automatic t_enable();
      wr(DREC_OFF_ENABLE, 32'h2);
      km.click(9, 30, 1'b1);
      repeat (300) @(posedge mclk);
      rd(DREC_OFF_COUNT1, 32'h1);
      rd(DREC_OFF_STATUS, 32'h0);
   endtask : t_enable
   task automatic t_glitch();
      // Pulse shorter than the 2 ms settle time must be dropped
      wr(DREC_OFF_ENABLE, 32'h3);
      km.move(9, 10);
      km.move(9, 60);
      repeat (300) @(posedge mclk);
      rd(DREC_OFF_COUNT1, 32'h1);
   endtask : t_glitch
   task automatic report_and_stop();
      $display("Checks %0d, errors %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : report_and_stop
   initial
   begin
      repeat (40000) @(posedge mclk);
      fail_count++;
      report_and_stop();
   end
   initial
   begin
      rst_n = 1'b0;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      bus_addr = 8'h00;
      bus_wdata = 32'h0;
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      t_reset();
      t_config();
      t_turn();
      t_preset();
      t_type2();
      t_route();
      t_enable();
      t_glitch();
      report_and_stop();
   end
endmodule : testbench
